// ===== src/pll_fastlock_init_control.sv
// programming latch control: fastlock, pump current, init pulse, power-down
`timescale 1ns/1ps
`include "pll_ctrl_defines.svh"

// Operation
// R01 - fastlock works only while the fastlock enable bit holds 1
// R02 - fastlock mode bit: 0 manual exit, 1 timer exit
// R03 - n load with gain bit 1 enters fastlock, secondary current
// R04 - manual variant exits only when a later n load writes gain 0
// R05 - timer variant clears stored gain bit itself when timeout expires
// R06 - timeout selection is function latch bits 14 down to 11
// R07 - gain set drives secondary current, otherwise primary current; here secondary only while the fastlock enable bit is 1
// R08 - timeout timer runs only in the timer-exit variant
// R09 - primary current from bits 15-17, secondary from bits 18-20
// R10 - three-state bit 1 floats the pump output, 0 enables it
// R11 - control bits 1,1 load init latch, same settings as function latch
// R12 - init load pulses reset: counters to load, pump three-stated
// R13 - init pulse triggers programmed synchronous power-down when chip enable high
// R14 - first n load after init repeats reset pulse, later ones do not
// R15 - chip enable low powers down, writes still accepted; high resumes
// R16 - latch contents survive chip enable power-down
// R17 - counter reset bit holds counters, floats pump, no sync power-down
// R18 - host init method: init, function, r load, n load
// R19 - host counter reset method: function f=1, r, n, function f=0
// R20 - host chip enable method: ce low, program, raise, allow settling
// R21 - 24-bit words msb first; latch enable rise loads latch by two lsbs
// R22 - function bit 2 is counter reset, holds r and n counters
// R23 - chip enable low powers down regardless of power-down bits
// R24 - each n load setting gain in timer variant restarts timeout; here an n load during power-down (pd_now) leaves the timer idle
module pll_fastlock_init_control
    import pll_ctrl_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  serial_clk,
    input  wire logic                  serial_data,
    input  wire logic                  latch_enable_pin,
    input  wire logic                  chip_enable,
    input  wire logic                  pump_event,
    output logic [2:0]                 pump_current,
    output logic                       pump_tristate,
    output logic                       fastlock_active,
    output logic                       counters_hold,
    output logic                       internal_reset_pulse,
    output logic                       device_powerdown,
    output logic [2:0]                 outmux_sel,
    output logic                       pd_polarity,
    output logic [13:0]                r_counter_value,
    output logic [12:0]                n_counter_value
);
    logic [`WORD_W-1:0] shift_word;
    logic [`WORD_W-1:0] function_settings_latch_reg, function_settings_latch_next;
    logic [13:0]        r_value_reg, r_value_next;
    logic [12:0]        n_value_reg, n_value_next;
    logic               pump_gain_bit_reg, pump_gain_bit_next;
    logic               init_armed_reg, init_armed_next;
    logic               reset_pulse_reg, reset_pulse_next;
    logic               sync_pd_reg, sync_pd_next;
    logic [2:0]         le_sync_reg, le_sync_next;
    logic [2:0]         ce_sync_reg, ce_sync_next;
    logic               le_level_reg, le_level_next;
    logic               ce_level_reg, ce_level_next;
    logic [`TIMER_W-1:0] timer_reg, timer_next;
    timer_state_e       tmr_state_reg, tmr_state_next;
    logic [2:0]         current_reg, current_next;
    logic               tristate_reg, tristate_next;
    logic               fastlock_reg, fastlock_next;
    logic               hold_reg, hold_next;
    logic               powerdown_reg, powerdown_next;

    // decoded fields of the stored function settings
    logic               counter_reset_bit;
    logic               powerdown_request;
    logic               powerdown_sync_select;
    logic               fastlock_enable;
    logic               fastlock_mode;
    logic [3:0]         timeout_sel;
    logic               load_strobe;
    latch_sel_e         load_sel;
    logic               n_load;
    logic               fn_load;
    logic               pd_now;

    // link-side shifting lives in the serial clock domain
    serial_word_shifter u_shifter
    (
        .serial_clk  (serial_clk),
        .serial_data (serial_data),
        .shift_word  (shift_word)
    );

    assign counter_reset_bit     = function_settings_latch_reg[`FN_COUNTER_RESET];          // R22
    assign powerdown_request     = function_settings_latch_reg[`FN_PD_REQUEST];
    assign powerdown_sync_select = function_settings_latch_reg[`FN_PD_SYNC];
    assign fastlock_enable       = function_settings_latch_reg[`FN_FL_ENABLE];              // R01
    assign fastlock_mode         = function_settings_latch_reg[`FN_FL_MODE];                // R02
    assign timeout_sel = function_settings_latch_reg[`FN_TIMEOUT_HI:`FN_TIMEOUT_LO];        // R06

    // pin synchronisers: a level counts once stages two and three agree
    always_comb
    begin
        le_sync_next  = {le_sync_reg[1:0], latch_enable_pin};
        ce_sync_next  = {ce_sync_reg[1:0], chip_enable};
        le_level_next = (le_sync_reg[1] == le_sync_reg[2]) ? le_sync_reg[2] : le_level_reg;
        ce_level_next = (ce_sync_reg[1] == ce_sync_reg[2]) ? ce_sync_reg[2] : ce_level_reg;
    end

    // word is stable while latch enable is high (host stops the serial clock), so the
    // synchronised rising edge qualifies the multi-bit crossing
    assign load_strobe = le_level_next & ~le_level_reg;                                      // R21
    assign load_sel    = latch_sel_e'(shift_word[`CTRL_HI:`CTRL_LO]);                        // R21
    assign n_load      = load_strobe && (load_sel == LATCH_N_COUNTER);
    assign fn_load     = load_strobe && (load_sel == LATCH_FUNCTION || load_sel == LATCH_INIT); // R11
    assign pd_now      = ~ce_level_reg | (powerdown_request & ~powerdown_sync_select) | sync_pd_reg; // R23

    // latch loading, gain bit and the internal reset pulse
    always_comb
    begin
        function_settings_latch_next = function_settings_latch_reg;
        r_value_next       = r_value_reg;
        n_value_next       = n_value_reg;
        pump_gain_bit_next = pump_gain_bit_reg;
        init_armed_next    = init_armed_reg;
        reset_pulse_next   = 1'b0;
        if (fn_load)
        begin
            function_settings_latch_next = shift_word;                                       // R11
        end
        if (load_strobe && load_sel == LATCH_R_COUNTER)
        begin
            r_value_next = shift_word[`R_VALUE_HI:`R_VALUE_LO];
        end
        if (load_strobe && load_sel == LATCH_INIT)
        begin
            reset_pulse_next = 1'b1;                                                         // R12
            init_armed_next  = 1'b1;                                                         // R14
        end
        if (n_load)
        begin
            n_value_next       = shift_word[`N_VALUE_HI:`N_VALUE_LO];
            pump_gain_bit_next = shift_word[`N_GAIN];                                        // R03 R04
            if (init_armed_reg)
            begin
                reset_pulse_next = 1'b1;                                                     // R14
                init_armed_next  = 1'b0;                                                     // R14
            end
        end
        else if (tmr_state_reg == TMR_EXPIRE)
        begin
            pump_gain_bit_next = 1'b0;                                                       // R05
        end
    end

    // synchronous power-down: armed by pd bits, taken on a pump event or the init pulse
    always_comb
    begin
        sync_pd_next = sync_pd_reg;
        if (!(powerdown_request && powerdown_sync_select) || !ce_level_reg)
        begin
            sync_pd_next = 1'b0;
        end
        else if (pump_event || reset_pulse_reg)
        begin
            sync_pd_next = 1'b1;                                                             // R13
        end
    end

    // timeout timer, counted in pump events; held idle at zero by the reset pulse or power-down
    always_comb
    begin
        timer_next     = timer_reg;
        tmr_state_next = tmr_state_reg;
        case (tmr_state_reg)
            TMR_IDLE:
            begin
                timer_next = `TIMER_ZERO;
            end
            TMR_RUN:
            begin
                if (pump_event)
                begin
                    timer_next = timer_reg - `TIMER_ONE;
                    if (timer_reg == `TIMER_ONE)
                    begin
                        tmr_state_next = TMR_EXPIRE;                                         // R05
                    end
                end
            end
            TMR_EXPIRE:
            begin
                tmr_state_next = TMR_IDLE;
            end
            default:
            begin
                tmr_state_next = TMR_IDLE;
            end
        endcase
        if (n_load && shift_word[`N_GAIN] && fastlock_enable && fastlock_mode)               // R08
        begin
            timer_next     = `TIMEOUT_BASE + `TIMEOUT_STEP * {2'b00, timeout_sel};           // R24
            tmr_state_next = TMR_RUN;                                                        // R24
        end
        // the pulse idles the timer as it is issued; an n load that issues it may still
        // start a fresh timeout, else the first gain load after init would never expire
        if ((reset_pulse_next && !n_load) || pd_now || !(fastlock_enable && fastlock_mode))
        begin
            timer_next     = `TIMER_ZERO;                                                    // R12 R08
            tmr_state_next = TMR_IDLE;
        end
    end

    // registered pump and counter controls
    always_comb
    begin
        fastlock_next  = fastlock_enable & pump_gain_bit_reg;                                // R01 R03
        current_next   = fastlock_next
                       ? function_settings_latch_reg[`FN_SECONDARY_HI:`FN_SECONDARY_LO]     // R07 R09
                       : function_settings_latch_reg[`FN_PRIMARY_HI:`FN_PRIMARY_LO];        // R09
        hold_next      = counter_reset_bit | reset_pulse_reg | pd_now;                       // R17 R22
        tristate_next  = function_settings_latch_reg[`FN_TRISTATE] | hold_next;              // R10 R12
        powerdown_next = pd_now;                                                             // R15
    end

    // pin synchroniser stages; chip enable reads low until it has settled
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            le_sync_reg  <= 3'h0;
            ce_sync_reg  <= 3'h0;
            le_level_reg <= 1'b0;
            ce_level_reg <= 1'b0;
        end
        else
        begin
            le_sync_reg  <= le_sync_next;
            ce_sync_reg  <= ce_sync_next;
            le_level_reg <= le_level_next;
            ce_level_reg <= ce_level_next;
        end
    end

    // latch contents only clear on system reset, never on chip enable
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            function_settings_latch_reg <= `FN_RESET_VALUE;                                  // R16
            r_value_reg       <= 14'h0000;
            n_value_reg       <= 13'h0000;
            pump_gain_bit_reg <= 1'b0;
            init_armed_reg    <= 1'b0;
            reset_pulse_reg   <= 1'b0;
        end
        else
        begin
            function_settings_latch_reg <= function_settings_latch_next;
            r_value_reg       <= r_value_next;
            n_value_reg       <= n_value_next;
            pump_gain_bit_reg <= pump_gain_bit_next;
            init_armed_reg    <= init_armed_next;
            reset_pulse_reg   <= reset_pulse_next;
        end
    end

    // synchronous power-down flag
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sync_pd_reg <= 1'b0;
        end
        else
        begin
            sync_pd_reg <= sync_pd_next;
        end
    end

    // timeout timer starts idle so no stale count survives a reset
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            timer_reg     <= `TIMER_ZERO;
            tmr_state_reg <= TMR_IDLE;
        end
        else
        begin
            timer_reg     <= timer_next;
            tmr_state_reg <= tmr_state_next;
        end
    end

    // pump floated and counters held out of reset until chip enable has settled
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            current_reg   <= 3'h0;
            tristate_reg  <= 1'b1;
            fastlock_reg  <= 1'b0;
            hold_reg      <= 1'b1;
            powerdown_reg <= 1'b1;
        end
        else
        begin
            current_reg   <= current_next;
            tristate_reg  <= tristate_next;
            fastlock_reg  <= fastlock_next;
            hold_reg      <= hold_next;
            powerdown_reg <= powerdown_next;
        end
    end

    assign pump_current         = current_reg;
    assign pump_tristate        = tristate_reg;
    assign fastlock_active      = fastlock_reg;
    assign counters_hold        = hold_reg;
    assign internal_reset_pulse = reset_pulse_reg;
    assign device_powerdown     = powerdown_reg;
    assign outmux_sel  = function_settings_latch_reg[`FN_OUTMUX_HI:`FN_OUTMUX_LO];
    assign pd_polarity = function_settings_latch_reg[`FN_PD_POLARITY];
    assign r_counter_value      = r_value_reg;
    assign n_counter_value      = n_value_reg;
endmodule

// ===== src/pll_ctrl_defines.svh
// bit positions, field widths and timing figures of the programming latches
`ifndef PLL_CTRL_DEFINES_SVH
`define PLL_CTRL_DEFINES_SVH

`define WORD_W              24
`define CTRL_LO             0
`define CTRL_HI             1
`define FN_COUNTER_RESET    2
`define FN_PD_REQUEST       3
`define FN_OUTMUX_LO        4
`define FN_OUTMUX_HI        6
`define FN_PD_POLARITY      7
`define FN_TRISTATE         8
`define FN_FL_ENABLE        9
`define FN_FL_MODE          10
`define FN_TIMEOUT_LO       11
`define FN_TIMEOUT_HI       14
`define FN_PRIMARY_LO       15
`define FN_PRIMARY_HI       17
`define FN_SECONDARY_LO     18
`define FN_SECONDARY_HI     20
`define FN_PD_SYNC          21
`define R_VALUE_LO          2
`define R_VALUE_HI          15
`define N_VALUE_LO          8
`define N_VALUE_HI          20
`define N_GAIN              21
`define FN_RESET_VALUE      24'h00_0000
// timeout in pump events: base + step * selection
`define TIMEOUT_BASE        6'h03
`define TIMEOUT_STEP        6'h04
`define TIMER_W             6
`define TIMER_ZERO          6'h00
`define TIMER_ONE           6'h01

`endif

// ===== src/pll_ctrl_pkg.sv
// types shared by the latch control logic
package pll_ctrl_pkg;
    typedef enum logic [1:0] {
        LATCH_R_COUNTER,
        LATCH_N_COUNTER,
        LATCH_FUNCTION,
        LATCH_INIT
    } latch_sel_e;
    typedef enum logic [1:0] {
        TMR_IDLE,
        TMR_RUN,
        TMR_EXPIRE
    } timer_state_e;
endpackage

// ===== src/serial_word_shifter.sv
// 24-bit input shift register clocked by the serial clock
`timescale 1ns/1ps
`include "pll_ctrl_defines.svh"

module serial_word_shifter
(
    input  wire logic                  serial_clk,
    input  wire logic                  serial_data,
    output logic [`WORD_W-1:0]         shift_word
);
    logic [`WORD_W-1:0] shift_reg;
    logic [`WORD_W-1:0] shift_next;

    // msb first: each rising edge pushes one bit in at the bottom
    always_comb
    begin
        shift_next = {shift_reg[`WORD_W-2:0], serial_data}; // R21
    end

    // no reset here: the serial clock may stand still, contents are don't-care until loaded
    always_ff @(posedge serial_clk)
    begin
        shift_reg <= shift_next;
    end

    assign shift_word = shift_reg;
endmodule

// ===== tb/pll_ctrl_properties.sv
// concurrent checks on the latch control block ports
`timescale 1ns/1ps
module pll_ctrl_checker
(
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       latch_enable_pin,
    input wire logic       chip_enable,
    input wire logic       pump_event,
    input wire logic [2:0] pump_current,
    input wire logic       pump_tristate,
    input wire logic       fastlock_active,
    input wire logic       counters_hold,
    input wire logic       internal_reset_pulse,
    input wire logic       device_powerdown
);
    logic [2:0] ev_age_reg;
    logic [2:0] ev_age_next;

    // cycles since the last pump event, saturating so it never wraps
    always_comb
    begin
        ev_age_next = (ev_age_reg == 3'h7) ? 3'h7 : ev_age_reg + 3'h1;
        if (pump_event)
            ev_age_next = 3'h0;
    end
    always_ff @(posedge clk)
        ev_age_reg <= sys_rst ? 3'h7 : ev_age_next;

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // pulse lasts one cycle, then counters held and pump floated
    sequence s_pulse_then_hold;
        internal_reset_pulse ##1 (!internal_reset_pulse && counters_hold && pump_tristate);
    endsequence
    sequence s_ce_low;
        !chip_enable [*6];
    endsequence
    property p_pulse_hold;
        internal_reset_pulse |-> s_pulse_then_hold;
    endproperty
    property p_pulse_on_load;
        internal_reset_pulse |-> latch_enable_pin;
    endproperty
    property p_hold_float;
        counters_hold [*2] |-> pump_tristate;
    endproperty
    property p_ce_fall;
        $fell(chip_enable) |-> ##[1:6] device_powerdown;
    endproperty
    property p_ce_low;
        s_ce_low |-> device_powerdown && counters_hold;
    endproperty
    property p_fl_rise;
        $rose(fastlock_active) |-> latch_enable_pin;
    endproperty
    property p_fl_fall;
        $fell(fastlock_active) && !latch_enable_pin |-> ev_age_reg < 3'h5;
    endproperty
    property p_current_cause;
        $changed(pump_current) |-> latch_enable_pin || ev_age_reg < 3'h5;
    endproperty
    a_pulse_hold:
        assert property (p_pulse_hold) else $error("reset pulse not followed by hold");
    a_pulse_on_load:
        assert property (p_pulse_on_load) else $error("reset pulse without a load");
    a_hold_float:
        assert property (p_hold_float) else $error("held counters with pump driven");
    a_ce_fall:
        assert property (p_ce_fall) else $error("chip enable low did not power down");
    a_ce_low:
        assert property (p_ce_low) else $error("powered up while chip enable low");
    a_fl_rise:
        assert property (p_fl_rise) else $error("fastlock entered without a load");
    a_fl_fall:
        assert property (p_fl_fall) else $error("fastlock left without pump event");
    a_current_cause:
        assert property (p_current_cause) else $error("pump current changed without cause");
endmodule

bind pll_fastlock_init_control pll_ctrl_checker u_chk (.clk(clk), .sys_rst(sys_rst),
    .latch_enable_pin(latch_enable_pin), .chip_enable(chip_enable), .pump_event(pump_event),
    .pump_current(pump_current), .pump_tristate(pump_tristate),
    .fastlock_active(fastlock_active), .counters_hold(counters_hold),
    .internal_reset_pulse(internal_reset_pulse), .device_powerdown(device_powerdown));

// ===== tb/serial_host_model.sv
// host model shifting 24-bit words into the serial programming port
`timescale 1ns/1ps
module serial_host_model
(
    input  wire logic        go,
    input  wire logic [23:0] word,
    output logic             serial_clk,
    output logic             serial_data,
    output logic             latch_enable_pin,
    output logic             done
);
    // one frame per go; link clock stands still between frames
    initial
    begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        latch_enable_pin = 1'b0;
        done = 1'b0;
        forever
        begin
            @(posedge go);
            done = 1'b0;
            for (int i = 23; i >= 0; i--)
            begin
                serial_data = word[i];
                #6 serial_clk = 1'b1;
                #6 serial_clk = 1'b0;
            end
            serial_data = ~serial_data; // data line flipped after the last bit, no stale bit
            #8 latch_enable_pin = 1'b1;
            #96 latch_enable_pin = 1'b0; // link stays still well past the load
            #48 done = 1'b1;
        end
    end
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the programming latch control block
`timescale 1ns/1ps
module tb_top;
    logic        clk, done, serial_clk, serial_data, latch_enable_pin, internal_reset_pulse;
    logic        fastlock_active, counters_hold, device_powerdown, pump_tristate, pd_polarity;
    logic        sys_rst = 1'b1;
    logic        chip_enable = 1'b1;
    logic        pump_event = 1'b0;
    logic        go = 1'b0;
    logic [2:0]  pump_current, outmux_sel;
    logic [13:0] r_counter_value;
    logic [12:0] n_counter_value;
    logic [23:0] word = 24'h00_0000;
    int          err_count = 0;
    int          checks_done = 0;
    int          pulses = 0;
    int          cycles = 0;

    pll_fastlock_init_control dut (.clk(clk), .sys_rst(sys_rst), .serial_clk(serial_clk),
        .serial_data(serial_data), .latch_enable_pin(latch_enable_pin),
        .chip_enable(chip_enable), .pump_event(pump_event), .pump_current(pump_current),
        .pump_tristate(pump_tristate), .fastlock_active(fastlock_active),
        .counters_hold(counters_hold), .internal_reset_pulse(internal_reset_pulse),
        .device_powerdown(device_powerdown), .outmux_sel(outmux_sel), .pd_polarity(pd_polarity),
        .r_counter_value(r_counter_value), .n_counter_value(n_counter_value));
    serial_host_model host (.go(go), .word(word), .serial_clk(serial_clk),
        .serial_data(serial_data), .latch_enable_pin(latch_enable_pin), .done(done));

    // 125 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // pulse tally and hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (internal_reset_pulse === 1'b1)
            pulses++;
        if (cycles == 20000)
        begin
            err_count++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string name, input logic [13:0] exp, input logic [13:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chkb(input string name, input logic exp, input logic got);
        chk(name, {13'h0000, exp}, {13'h0000, got});
    endtask
    task automatic ev(input int n);
        repeat (n)
        begin
            pump_event = 1'b1;
            tick(1);
            pump_event = 1'b0;
            tick(1);
        end
    endtask
    // one whole frame, bounded wait for the host model
    task automatic send(input logic [23:0] w);
        int k;
        word = w;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        for (k = 0; k < 200 && done !== 1'b1; k++)
            tick(1);
        if (k == 200)
            chkb("frame", 1'b1, 1'b0);
    endtask
    // flags are {sync pd, mode, enable, float, pd, counter reset}
    function automatic logic [23:0] fw(input logic [1:0] c, input logic [5:0] f,
        input logic [3:0] ts);
        return {2'b00, f[5], 3'b110, 3'b010, ts, f[4], f[3], f[2], 1'b1, 3'b101, f[1], f[0], c};
    endfunction
    function automatic logic [23:0] nw(input logic g);
        return {2'b00, g, 13'h0123, 6'h00, 2'b01};
    endfunction

    task automatic t_init();
        int p0;
        p0 = pulses;
        send(fw(2'b11, 6'h18, 4'h1));
        chk("pulses", 14'(p0 + 1), 14'(pulses));
        send(fw(2'b10, 6'h18, 4'h1));
        send({8'h00, 14'h0abc, 2'b00});
        chk("r value", 14'h0abc, r_counter_value);
        send(nw(1'b0));
        send(nw(1'b0));
        chk("pulses", 14'(p0 + 2), 14'(pulses));
        chk("n value", 14'h0123, 14'(n_counter_value));
        chk("current", 14'h0002, 14'(pump_current));
        chk("outmux", 14'h0005, 14'(outmux_sel));
        chkb("float", 1'b0, pump_tristate);
        chkb("polarity", 1'b1, pd_polarity);
    endtask
    // timeout of 3 + 4 * sel events, restarted by a second gain load
    task automatic t_timer();
        send(nw(1'b1));
        chkb("fastlock", 1'b1, fastlock_active);
        chk("current", 14'h0006, 14'(pump_current));
        ev(6);
        send(nw(1'b1));
        ev(6);
        chkb("fastlock", 1'b1, fastlock_active);
        ev(1);
        tick(4);
        chkb("fastlock", 1'b0, fastlock_active);
        chk("current", 14'h0002, 14'(pump_current));
    endtask
    task automatic t_manual();
        send(fw(2'b10, 6'h08, 4'h0));
        send(nw(1'b1));
        ev(12);
        chkb("fastlock", 1'b1, fastlock_active);
        send(nw(1'b0));
        chkb("fastlock", 1'b0, fastlock_active);
        send(fw(2'b10, 6'h10, 4'h0));
        send(nw(1'b1));
        chkb("fastlock", 1'b0, fastlock_active);
        chk("current", 14'h0002, 14'(pump_current));
        send(nw(1'b0));
    endtask
    task automatic t_bits();
        send(fw(2'b10, 6'h04, 4'h0));
        chkb("float", 1'b1, pump_tristate);
        chkb("hold", 1'b0, counters_hold);
        send(fw(2'b10, 6'h01, 4'h0));
        send(nw(1'b0));
        ev(2);
        chkb("hold", 1'b1, counters_hold);
        chkb("powerdown", 1'b0, device_powerdown);
        send(fw(2'b10, 6'h00, 4'h0));
        chkb("float", 1'b0, pump_tristate);
    endtask
    task automatic t_ce();
        chip_enable = 1'b0;
        tick(6);
        chkb("powerdown", 1'b1, device_powerdown);
        send({8'h00, 14'h1555, 2'b00});
        chip_enable = 1'b1;
        tick(8);
        chkb("powerdown", 1'b0, device_powerdown);
        chk("r value", 14'h1555, r_counter_value);
        chk("outmux", 14'h0005, 14'(outmux_sel));
    endtask
    task automatic t_pd();
        send(fw(2'b10, 6'h02, 4'h0));
        chkb("powerdown", 1'b1, device_powerdown);
        send(fw(2'b10, 6'h23, 4'h0));
        chkb("powerdown", 1'b0, device_powerdown);
        ev(1);
        chkb("powerdown", 1'b1, device_powerdown);
        send(fw(2'b10, 6'h00, 4'h0));
        send(fw(2'b11, 6'h22, 4'h0));
        chkb("powerdown", 1'b1, device_powerdown);
    endtask

    // main sequence
    initial
    begin
        tick(3);
        sys_rst = 1'b0;
        tick(6);
        t_init();
        t_timer();
        t_manual();
        t_bits();
        t_ce();
        t_pd();
        conclude();
    end
endmodule
